//--- hw/wwd_top.sv
// Windowed watchdog timer with APB registers, interrupt and reset output
//
// Notes on behaviour
// [RQ1] 16-bit counter at clock/2 or clock/128
// [RQ2] Two byte stages, low byte cleared on service
// [RQ3] Service loads high byte with reload byte
// [RQ4] Overflow raises timeout flag, enters prewarning
// [RQ5] Prewarning lasts 30h ticks, then system reset
// [RQ6] Service inside window: prewarning, no timeout flag
// [RQ7] Window spans zero up to window byte:00
// [RQ8] Debug mode suspends counting by default
// [RQ9] Period set by prescale and reload byte
// [RQ10] Window byte above reload shortens service period
// [RQ11] Software keeps window byte not below reload
// [RQ12] Service is one-cycle strobe from register write
// [RQ13] Window checked only while window enable set
`timescale 1ns/1ps
`default_nettype none
module wwd_top
	import wwd_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// Debug halt from the core
	input  wire logic        debug_mode,
	// Watchdog outputs
	output logic             timeout_nmi_flag,
	output logic             watchdog_system_reset,
	output logic             irq
);
	initial begin
		if (CNT_W != 16)
			$error("wwd_top: counter must be 16 bits wide");
	end

	// Decode of a word address against the map, used for each of the seven words
	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
		is_addr = (a[7:2] == ref_a[7:2]);
	endfunction

	// Software-visible registers
	logic [CTRL_W-1:0]  ctrl;        // Enable, prescale, window enable, debug run
	logic [STAGE_W-1:0] reload_high_byte;     // High byte loaded by a service
	logic [STAGE_W-1:0] window_boundary_byte; // High byte of the window end
	logic [EVT_W-1:0]   status;      // Sticky events
	logic [EVT_W-1:0]   mask;        // Interrupt mask of the events

	// Watchdog state
	wwd_phase_e         phase;       // Run, prewarning or expired
	logic [7:0]         pw_cnt;      // Prewarning ticks elapsed
	wire  [CNT_W-1:0]   count;       // Joined counter value, driven by the stages

	// Bus decode
	wire access    = psel & penable;
	wire setup     = psel & ~penable;
	wire wr        = access & pwrite;
	wire hit_ctrl  = is_addr(paddr, ADDR_CTRL);
	wire hit_rel   = is_addr(paddr, ADDR_RELOAD);
	wire hit_win   = is_addr(paddr, ADDR_WINDOW);
	wire hit_svc   = is_addr(paddr, ADDR_SERVICE);
	wire hit_stat  = is_addr(paddr, ADDR_STATUS);
	wire hit_mask  = is_addr(paddr, ADDR_MASK);
	wire hit_cnt   = is_addr(paddr, ADDR_COUNT);
	wire mapped    = hit_ctrl | hit_rel | hit_win | hit_svc |
	                 hit_stat | hit_mask | hit_cnt;

	// Zero wait states: read data were latched in the setup cycle
	assign pready  = 1'b1;
	// Unmapped words, and a read of the write-only service word, fail
	assign pslverr = access & (~mapped | (hit_svc & ~pwrite));

	// Write strobes
	wire wr_ok    = wr & mapped;
	wire wr_ctrl  = wr_ok & hit_ctrl;
	wire wr_rel   = wr_ok & hit_rel;
	wire wr_win   = wr_ok & hit_win;
	wire wr_stat  = wr_ok & hit_stat;
	wire wr_mask  = wr_ok & hit_mask;

	// [RQ12] service write strobe
	// The data word is ignored; the write itself is the one-cycle strobe
	wire svc_strobe = wr_ok & hit_svc;

	// Control fields
	wire en       = ctrl[CTRL_EN];
	wire slow_sel = ctrl[CTRL_PRESEL];
	wire win_en   = ctrl[CTRL_WIN_EN];
	wire dbg_run  = ctrl[CTRL_DBG_RUN];

	// [RQ8] debug suspend
	// Halted core cannot service, so counting stops unless allowed
	wire suspended = debug_mode & ~dbg_run;

	// Prescaler keeps running through prewarning so that phase ends too
	wire run_clk   = en & ~suspended & (phase != WWD_EXPIRED);
	wire tick;

	// [RQ1] count rate select
	wwd_prescaler #(
		.PRE_W   (7)
	) u_pre (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.run     (run_clk),
		.slow_sel(slow_sel),
		.tick    (tick)
	);

	// Counting only advances in the run phase
	wire in_run = (phase == WWD_RUN);
	wire cnt_inc = tick & in_run;

	// [RQ7] forbidden window
	// Window end is the boundary byte over a zero low byte; strictly below
	wire [CNT_W-1:0] win_end = {window_boundary_byte, {STAGE_W{1'b0}}};
	// [RQ10] shortened service period
	// Earliest legal service is at the window end, so with a window
	// byte above the reload byte the usable period follows the window.
	wire in_window = count < win_end;

	// [RQ13] window gate
	// With window checking off, every service while enabled and in the run phase is accepted
	wire svc_bad  = svc_strobe & en & in_run & win_en & in_window;
	wire svc_good = svc_strobe & en & in_run & ~svc_bad;

	// [RQ2] chained byte stages
	// Low stage clears and high stage reloads on a good service
	wire [STAGE_W-1:0] stage_load_val [NUM_STAGE];
	wire [NUM_STAGE:0] stage_carry;
	assign stage_carry[0]    = cnt_inc;
	assign stage_load_val[0] = '0;
	// [RQ3] high byte reload
	// Counting resumes from reload byte times 256
	assign stage_load_val[1] = reload_high_byte;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_STAGE; gi++) begin : g_stage
			wwd_byte_stage #(
				.W       (STAGE_W)
			) u_stage (
				.ref_clk (ref_clk),
				.rstn    (rstn),
				.load    (svc_good),
				.load_val(stage_load_val[gi]),
				.inc     (stage_carry[gi] & ~svc_good),
				.value   (count[gi*STAGE_W +: STAGE_W]),
				.carry   (stage_carry[gi+1])
			);
		end
	endgenerate

	// [RQ9] overflow of the full counter
	// Period follows from prescale and reload alone: carry out of the top
	wire overflow = stage_carry[NUM_STAGE] & ~svc_good;

	// [RQ11] software ordering
	// A window byte below the reload byte leaves the window useless.

	// Prewarning progress
	wire pw_tick = tick & (phase == WWD_PREWARN);
	// [RQ5] prewarning length
	wire pw_done = pw_tick & (pw_cnt == PREWARN_COUNTS - 8'h01);

	// Next phase
	wwd_phase_e next_phase;
	always_comb begin
		next_phase = phase;
		unique case (phase)
			// [RQ4] overflow enters prewarning
			WWD_RUN: begin
				if (overflow | svc_bad)
					next_phase = WWD_PREWARN;
			end
			// [RQ5] prewarning then reset
			WWD_PREWARN: begin
				if (pw_done)
					next_phase = WWD_EXPIRED;
			end
			// Only system reset leaves this phase
			WWD_EXPIRED: begin
				next_phase = WWD_EXPIRED;
			end
			// Illegal one-hot code: fall back to expiry, the safe side
			default: begin
				next_phase = WWD_EXPIRED;
			end
		endcase
	end

	// Phase register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			phase <= WWD_RUN;
		else
			phase <= next_phase;
	end

	// Prewarning tick counter, cleared outside prewarning
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			pw_cnt <= '0;
		else if (phase != WWD_PREWARN)
			pw_cnt <= '0;
		else if (pw_tick)
			pw_cnt <= pw_cnt + 8'h01;
	end

	// [RQ5] system reset output
	// Held high until the system reset returns on rstn
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			watchdog_system_reset <= 1'b0;
		else if (pw_done)
			watchdog_system_reset <= 1'b1;
	end

	// Event sources
	wire [EVT_W-1:0] evt_set;
	// [RQ4] timeout flag source
	assign evt_set[ST_TIMEOUT] = overflow & in_run;
	// [RQ6] bad service, no timeout flag
	assign evt_set[ST_BAD_SVC] = svc_bad;

	// Write-one-to-clear, but an arriving event wins over its clear
	wire [EVT_W-1:0] evt_clr     = wr_stat ? pwdata[EVT_W-1:0] : '0;
	wire [EVT_W-1:0] next_status = (status & ~evt_clr) | evt_set;

	// Sticky status
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			status <= '0;
		else
			status <= next_status;
	end

	// [RQ4] non-maskable timeout flag
	// Not gated by the mask: it is the non-maskable request
	assign timeout_nmi_flag = status[ST_TIMEOUT];

	// Maskable interrupt, high while any unmasked event is pending
	assign irq = |(status & mask);

	// Control and configuration registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl                 <= CTRL_RST;
			reload_high_byte     <= RELOAD_RST;
			window_boundary_byte <= WINDOW_RST;
			mask                 <= MASK_RST;
		end else begin
			if (wr_ctrl)
				ctrl <= pwdata[CTRL_W-1:0];
			if (wr_rel)
				reload_high_byte <= pwdata[STAGE_W-1:0];
			if (wr_win)
				window_boundary_byte <= pwdata[STAGE_W-1:0];
			if (wr_mask)
				mask <= pwdata[EVT_W-1:0];
		end
	end

	// Live status view beside the sticky bits
	wire [31:0] stat_word = {28'h0000000, watchdog_system_reset,
	                         phase == WWD_PREWARN, status};

	// Read selection; unmapped and service words read zero
	wire [31:0] rd_mux =
		hit_ctrl ? {28'h0000000, ctrl} :
		hit_rel  ? {24'h000000, reload_high_byte} :
		hit_win  ? {24'h000000, window_boundary_byte} :
		hit_stat ? stat_word :
		hit_mask ? {30'h00000000, mask} :
		hit_cnt  ? {16'h0000, count} :
		32'h00000000;

	// Read data captured in the setup cycle, so it is a flop at access
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			prdata <= '0;
		else if (setup & ~pwrite)
			prdata <= rd_mux;
	end
endmodule
`default_nettype wire

//--- inc/wwd_pkg.sv
// Package of register map, field positions and constants for the windowed watchdog
`default_nettype none
package wwd_pkg;
	// Counter geometry: two chained byte stages
	localparam int STAGE_W   = 8;
	localparam int NUM_STAGE = 2;
	localparam int CNT_W     = STAGE_W * NUM_STAGE;

	// Prescaler ratios of the count rate
	localparam int DIV_FAST = 2;
	localparam int DIV_SLOW = 128;

	// Length of the reset prewarning phase in count ticks
	localparam logic [7:0] PREWARN_COUNTS = 8'h30;

	// APB byte addresses
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_RELOAD  = 8'h04;
	localparam logic [7:0] ADDR_WINDOW  = 8'h08;
	localparam logic [7:0] ADDR_SERVICE = 8'h0C;
	localparam logic [7:0] ADDR_STATUS  = 8'h10;
	localparam logic [7:0] ADDR_MASK    = 8'h14;
	localparam logic [7:0] ADDR_COUNT   = 8'h18;

	// Control register fields
	localparam int CTRL_EN     = 0;
	localparam int CTRL_PRESEL = 1;
	localparam int CTRL_WIN_EN = 2;
	localparam int CTRL_DBG_RUN = 3;
	localparam int CTRL_W      = 4;

	// Status register fields: sticky events, then live state
	localparam int ST_TIMEOUT  = 0;
	localparam int ST_BAD_SVC  = 1;
	localparam int EVT_W       = 2;
	localparam int ST_PREWARN  = 2;
	localparam int ST_SYSRST   = 3;

	// Reset values
	localparam logic [CTRL_W-1:0]  CTRL_RST   = 4'h0;
	localparam logic [STAGE_W-1:0] RELOAD_RST = 8'h00;
	localparam logic [STAGE_W-1:0] WINDOW_RST = 8'h00;
	localparam logic [EVT_W-1:0]   MASK_RST   = 2'h0;

	// Phase of the watchdog
	typedef enum logic [2:0] {
		WWD_RUN     = 3'b001,
		WWD_PREWARN = 3'b010,
		WWD_EXPIRED = 3'b100
	} wwd_phase_e;
endpackage
`default_nettype wire

//--- hw/wwd_prescaler.sv
// Count-rate prescaler: one tick every 2 or 128 clock cycles
`timescale 1ns/1ps
`default_nettype none
module wwd_prescaler
	import wwd_pkg::*;
#(
	parameter int PRE_W = 7
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Control
	input  wire logic run,
	input  wire logic slow_sel,
	// Count tick
	output logic      tick
);
	// Divider must reach the slow ratio
	initial begin
		if ((1 << PRE_W) < DIV_SLOW)
			$error("wwd_prescaler: PRE_W too small");
	end

	localparam logic [PRE_W-1:0] LAST_FAST = PRE_W'(DIV_FAST - 1);
	localparam logic [PRE_W-1:0] LAST_SLOW = PRE_W'(DIV_SLOW - 1);

	logic [PRE_W-1:0] div_cnt;   // Free divider
	wire              div_last;  // Divider at its final value

	// Low bits only decide the fast rate, all bits the slow one
	assign div_last = slow_sel ? (div_cnt == LAST_SLOW)
	                           : ((div_cnt & LAST_FAST) == LAST_FAST);
	assign tick     = run & div_last;

	// Divider holds while counting is suspended
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			div_cnt <= '0;
		else if (run)
			div_cnt <= div_last & slow_sel ? '0 : div_cnt + 1'b1;
	end
endmodule
`default_nettype wire

//--- hw/wwd_byte_stage.sv
// One byte stage of the chained watchdog counter
`timescale 1ns/1ps
`default_nettype none
module wwd_byte_stage
	import wwd_pkg::*;
#(
	parameter int W = STAGE_W
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	// Control
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         inc,
	// State
	output logic [W-1:0]      value,
	output logic              carry
);
	initial begin
		if (W < 1)
			$error("wwd_byte_stage: W must be positive");
	end

	// Carry fires when an increment wraps this stage
	assign carry = inc & (&value);

	// Load beats increment: a good service always restarts the stage
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			value <= '0;
		else if (load)
			value <= load_val;
		else if (inc)
			value <= value + 1'b1;
	end
endmodule
`default_nettype wire

//--- verif/wwd_chk.sv
// Port assertions for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module wwd_chk
	import wwd_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rstn,
	// APB slave side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// Debug and watchdog outputs
	input wire logic        debug_mode,
	input wire logic        timeout_nmi_flag,
	input wire logic        watchdog_system_reset,
	input wire logic        irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Access phase and word index; low address bits are ignored
	wire       acc = psel & penable;
	wire [5:0] wd  = paddr[7:2];
	// One written to the timeout bit of the status word
	wire       clr = acc & pwrite & (wd == 6'h4) & pwdata[0];

	a_ready_high: assert property (pready) else $error("pready low");
	a_err_unmapped: assert property (acc && !pwrite && wd > 6'h6 |-> pslverr && prdata == 0)
		else $error("unmapped read not refused");
	a_err_svc_read: assert property (acc && !pwrite && wd == 6'h3 |-> pslverr)
		else $error("service read not refused");
	a_err_mapped: assert property (acc && wd <= 6'h6 && (pwrite || wd != 6'h3) |-> !pslverr)
		else $error("mapped access refused");
	a_rst_sticky: assert property (watchdog_system_reset |=> watchdog_system_reset)
		else $error("system reset dropped");
	a_prewarn_min: assert property ($rose(timeout_nmi_flag) && !watchdog_system_reset
		|-> !watchdog_system_reset [*8]) else $error("prewarning too short");
	a_nmi_sticky: assert property (timeout_nmi_flag && !clr |=> timeout_nmi_flag)
		else $error("timeout flag lost");
	a_nmi_cleared: assert property (timeout_nmi_flag && clr |=> !timeout_nmi_flag)
		else $error("timeout flag not cleared");

	// Main scenarios reached
	c_timeout: cover property ($rose(timeout_nmi_flag));
	c_sysrst: cover property ($rose(watchdog_system_reset));
	c_irq_bad: cover property (irq && !timeout_nmi_flag);
endmodule
bind wwd_top wwd_chk u_wwd_chk (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .prdata(prdata), .debug_mode(debug_mode),
	.timeout_nmi_flag(timeout_nmi_flag), .watchdog_system_reset(watchdog_system_reset),
	.irq(irq));
`default_nettype wire

//--- verif/test_wwd_top.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module test_wwd_top;
	import wwd_pkg::*;
	logic        ref_clk, rstn, psel, penable, pwrite, debug_mode;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, d, a;
	logic        pready, pslverr, e, nmi, srst, irq;
	int          bad_count, checks, n;

	wwd_top u_wwd_top (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata),
		.debug_mode(debug_mode), .timeout_nmi_flag(nmi),
		.watchdog_system_reset(srst), .irq(irq));

	// 50 ns clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, s, x);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One APB transfer; request held until pready is seen
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] v);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= v;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (int t = 0; t <= 20; t++) begin
			@(posedge ref_clk);
			if (pready === 1'b1)
				break;
			if (t == 20) begin
				bad_count++;
				conclude();
			end
		end
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so the next call never re-raises psel in this step
		@(posedge ref_clk);
	endtask

	// Edges until nmi (r=0) or system reset (r=1) is seen, bounded
	task automatic rise(input bit r, input int lim);
		for (n = 0; (r ? srst : nmi) !== 1'b1; n++) begin
			if (n == lim) begin
				bad_count++;
				conclude();
			end
			@(posedge ref_clk);
		end
	endtask

	// Reset held for 8 cycles; also the only way out of system reset
	task automatic rst();
		rstn <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
	endtask

	// Reset values, masking of wide writes, refusals
	task automatic t_regs();
		for (int i = 0; i < 4; i++) begin
			apb(0, (i == 3) ? ADDR_MASK : 8'(i * 4), 0);
			chk(d, 0);
		end
		apb(1, ADDR_RELOAD, 32'hFFFFFFA5);
		apb(0, ADDR_RELOAD, 0);
		chk(d, 32'hA5);
		apb(1, 8'h1C, 32'hFF);
		apb(0, 8'h1C, 0);
		chk({e, d[30:0]}, 32'h80000000);
		apb(0, ADDR_SERVICE, 0);
		chk(e, 1);
		$display("regs done");
	endtask

	// Service, window end, overflow period, prewarning, interrupt
	task automatic t_timeout();
		apb(1, ADDR_RELOAD, 32'hFE);
		apb(1, ADDR_WINDOW, 32'hFF);
		apb(1, ADDR_CTRL, 32'h1);
		apb(1, ADDR_SERVICE, 0);
		apb(0, ADDR_COUNT, 0);
		chk(d[15:8], 8'hFE);
		chk(32'(d[7:0] < 2), 1);
		// Window on: the window byte opens legal service 512 cycles after it
		apb(1, ADDR_CTRL, 32'h5);
		repeat (530) @(posedge ref_clk);
		apb(1, ADDR_SERVICE, 0);
		apb(0, ADDR_STATUS, 0);
		chk(d[2:0], 0);
		rise(0, 1100);
		chk(32'(n > 1018 && n < 1028), 1);
		rise(1, 200);
		chk(32'(n > 91 && n < 101), 1);
		apb(0, ADDR_STATUS, 0);
		chk({d[3], d[1:0]}, 3'b101);
		chk(irq, 0);
		apb(1, ADDR_MASK, 1);
		@(posedge ref_clk);
		chk(irq, 1);
		apb(1, ADDR_STATUS, 1);
		@(posedge ref_clk);
		chk({nmi, irq}, 0);
		rst();
		$display("timeout done");
	endtask

	// Window boundary, bad service, window enable off
	task automatic t_window();
		apb(1, ADDR_WINDOW, 32'h10);
		apb(1, ADDR_CTRL, 32'h1);
		apb(1, ADDR_SERVICE, 0);
		apb(0, ADDR_STATUS, 0);
		chk(d[2:0], 0);
		apb(1, ADDR_WINDOW, 32'h01);
		apb(1, ADDR_CTRL, 32'h5);
		repeat (530) @(posedge ref_clk);
		apb(1, ADDR_SERVICE, 0);
		apb(0, ADDR_STATUS, 0);
		chk(d[2:0], 0);
		apb(1, ADDR_MASK, 2);
		apb(1, ADDR_SERVICE, 0);
		@(posedge ref_clk);
		chk(irq, 1);
		apb(0, ADDR_STATUS, 0);
		chk(d[2:0], 3'b110);
		rise(1, 200);
		chk(nmi, 0);
		rst();
		$display("window done");
	endtask

	// Debug freeze, debug run allowed, then slow prescale
	task automatic t_debug();
		apb(1, ADDR_CTRL, 32'h1);
		debug_mode <= 1'b1;
		apb(0, ADDR_COUNT, 0);
		a = d;
		repeat (100) @(posedge ref_clk);
		apb(0, ADDR_COUNT, 0);
		chk(d, a);
		// Debug run bit set: counting goes on although the core is halted
		apb(1, ADDR_CTRL, 32'h9);
		repeat (10) @(posedge ref_clk);
		apb(0, ADDR_COUNT, 0);
		chk(32'(d > a), 1);
		debug_mode <= 1'b0;
		apb(1, ADDR_CTRL, 32'h3);
		apb(0, ADDR_COUNT, 0);
		a = d;
		repeat (254) @(posedge ref_clk);
		apb(0, ADDR_COUNT, 0);
		chk(32'(d - a > 0 && d - a < 4), 1);
		$display("debug done");
	endtask

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		debug_mode = 1'b0;
		bad_count = 0;
		checks = 0;
		rst();
		t_regs();
		t_timeout();
		t_window();
		t_debug();
		conclude();
	end
endmodule
`default_nettype wire
